// file: design/block_table_consts.svh
`ifndef BLOCK_TABLE_CONSTS_SVH
`define BLOCK_TABLE_CONSTS_SVH
// ==========================================
// table geometry
`define BT_SLOTS        64
`define BT_IDX_W        6
`define BT_MAX_BLOCK_NO 8'h3f
`define BT_NO_RST       8'hff
// ==========================================
// mode word digit positions (hex digits, xXxx order)
`define MODE_SRC_LSB    12
`define MODE_CHG_LSB    8
`define MODE_POS_LSB    4
`define MODE_SKIP_LSB   0
// ==========================================
// fieldbus control word bit positions
`define CW_JOG_ONE_BIT  8
`define CW_JOG_TWO_BIT  9
`define PCW_STEP_BIT    5
// ==========================================
// terminal function numbers
`define FN_JOG_ONE      8'h3e
`define FN_JOG_TWO      8'h3f
`define FN_STEP_JOG     8'h3d
`define TERM_COUNT      4
`endif

// file: design/block_table_drive.sv
`include "block_table_consts.svh"
// How it works
// - sixty-four block slots, indexed by slot
// - start only if block number 0..63
// - position field gives block target
// - velocity field gives travel speed
// - accel override scales maximum acceleration
// - decel override scales maximum deceleration
// - command code decoded to command kind
// - parameter field carries command operand
// - second mode digit selects block change
// - third mode digit selects positioning mode
// - first mode digit selects target source
// - jog one from terminal 62 or bit 8
// - jog two from terminal 63 or bit 9
// - step jog from terminal 61 or bit 5
// - each jog has own speed setpoint
// - each jog has own step distance
// - jog direction from speed setpoint sign
// - release stops; next request restarts task
// - both jog requests together raise fault
module block_table_drive (
  input  wire logic        clk,               // drive clock
  input  wire logic        sys_rst,           // sync reset
  block_table_if.drive     bus,               // link
  input  wire logic [31:0] max_accel_param,   // maximum acceleration
  input  wire logic [31:0] max_decel_param,   // maximum deceleration
  input  wire logic [31:0] jog_one_speed_setpoint, // signed
  input  wire logic [31:0] jog_two_speed_setpoint, // signed
  input  wire logic [31:0] jog_one_step_distance,  // step length
  input  wire logic [31:0] jog_two_step_distance,  // step length
  output logic             blk_valid_r,       // started block accepted
  output logic             blk_reject_r,      // start refused (pulse)
  output logic [31:0]      blk_target_r,      // target position
  output logic [31:0]      blk_vel_r,         // travel velocity
  output logic [39:0]      blk_accel_r,       // scaled acceleration
  output logic [39:0]      blk_decel_r,       // scaled deceleration
  output block_table_pkg::cmd_t blk_cmd_r,    // decoded command
  output logic [15:0]      blk_par_r,         // command operand
  output block_table_pkg::chg_t blk_chg_r,    // block change mode
  output block_table_pkg::pos_t blk_pos_r,    // positioning mode
  output logic             blk_src_bus_r,     // target from fieldbus
  output logic             blk_skip_r,        // skip flag
  output logic             jog_active_r,      // jog motion running
  output logic             jog_dir_neg_r,     // direction minus
  output logic [31:0]      jog_speed_r,       // magnitude of speed
  output logic             jog_step_r,        // incremental jog
  output logic [31:0]      jog_dist_r,        // step distance
  output logic             jog_fault_r        // both jogs at once
);
  import block_table_pkg::*;
  // ==========================================
  // parallel field storage
  logic [7:0]  no_mem   [0:`BT_SLOTS-1];
  logic [31:0] pos_mem  [0:`BT_SLOTS-1];
  logic [31:0] vel_mem  [0:`BT_SLOTS-1];
  logic [7:0]  acc_mem  [0:`BT_SLOTS-1];
  logic [7:0]  dec_mem  [0:`BT_SLOTS-1];
  logic [3:0]  cmd_mem  [0:`BT_SLOTS-1];
  logic [15:0] par_mem  [0:`BT_SLOTS-1];
  logic [15:0] mode_mem [0:`BT_SLOTS-1];

  // table write, no reset on data memories
  always_ff @(posedge clk) begin
    if (bus.wr_stb) begin
      pos_mem[bus.wr_slot]  <= bus.wr_pos;
      vel_mem[bus.wr_slot]  <= bus.wr_vel;
      acc_mem[bus.wr_slot]  <= bus.wr_acc;
      dec_mem[bus.wr_slot]  <= bus.wr_dec;
      cmd_mem[bus.wr_slot]  <= bus.wr_cmd;
      par_mem[bus.wr_slot]  <= bus.wr_par;
      mode_mem[bus.wr_slot] <= bus.wr_mode;
    end
  end
  // block numbers reset to invalid so unprogrammed slots cannot start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `BT_SLOTS; i++) no_mem[i] <= `BT_NO_RST;
    end else if (bus.wr_stb) begin
      no_mem[bus.wr_slot] <= bus.wr_no;
    end
  end

  // ==========================================
  // block start: read all fields of the slot together
  logic [7:0]  rd_no;
  logic [15:0] rd_mode;
  logic [3:0]  rd_cmd;
  logic        rd_ok;
  cmd_t        cmd_dec;
  assign rd_no   = no_mem[bus.start_slot];
  assign rd_mode = mode_mem[bus.start_slot];
  assign rd_cmd  = cmd_mem[bus.start_slot];
  assign rd_ok   = (rd_no <= `BT_MAX_BLOCK_NO);
  // command decode, unknown codes map to none
  always_comb begin
    case (rd_cmd)
      4'h1:    cmd_dec = CMD_POSITION;
      4'h2:    cmd_dec = CMD_RUN_PLUS;
      4'h3:    cmd_dec = CMD_RUN_MINUS;
      4'h4:    cmd_dec = CMD_WAIT;
      4'h5:    cmd_dec = CMD_JUMP;
      4'h6:    cmd_dec = CMD_SET_OUT;
      4'h7:    cmd_dec = CMD_CLR_OUT;
      4'h8:    cmd_dec = CMD_HARD_STOP;
      4'h9:    cmd_dec = CMD_COUPLE;
      4'ha:    cmd_dec = CMD_UNCOUPLE;
      default: cmd_dec = CMD_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_valid_r <= 1'b0;
      blk_reject_r <= 1'b0;
      blk_target_r <= 32'h0;
      blk_vel_r <= 32'h0;
      blk_accel_r <= 40'h0;
      blk_decel_r <= 40'h0;
      blk_cmd_r <= CMD_NONE;
      blk_par_r <= 16'h0;
      blk_chg_r <= CHG_END;
      blk_pos_r <= POS_ABS;
      blk_src_bus_r <= 1'b0;
      blk_skip_r <= 1'b0;
    end else begin
      blk_reject_r <= bus.start_stb && !rd_ok;
      if (bus.start_stb && rd_ok) begin
        blk_valid_r <= 1'b1;
        blk_target_r <= pos_mem[bus.start_slot];
        blk_vel_r <= vel_mem[bus.start_slot];
        // product of override and maximum, override in 1/256 units
        blk_accel_r <= 40'(acc_mem[bus.start_slot])
                       * 40'(max_accel_param);
        blk_decel_r <= 40'(dec_mem[bus.start_slot])
                       * 40'(max_decel_param);
        blk_cmd_r <= cmd_dec;
        blk_par_r <= par_mem[bus.start_slot];
        blk_chg_r <= chg_t'(rd_mode[`MODE_CHG_LSB +: 2]);
        blk_pos_r <= pos_t'(rd_mode[`MODE_POS_LSB +: 2]);
        blk_src_bus_r <= rd_mode[`MODE_SRC_LSB];
        blk_skip_r <= rd_mode[`MODE_SKIP_LSB];
      end else if (bus.start_stb) begin
        blk_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // jog request sources: terminals pass two flops first
  logic [3:0] term_s1_r;
  logic [3:0] term_s2_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      term_s1_r <= 4'h0;
      term_s2_r <= 4'h0;
    end else begin
      term_s1_r <= bus.term_level;
      term_s2_r <= term_s1_r;
    end
  end
  logic req_one;
  logic req_two;
  logic req_step;
  // or-combine terminals by function number with control word bits
  always_comb begin
    req_one  = bus.ctrl_word[`CW_JOG_ONE_BIT];
    req_two  = bus.ctrl_word[`CW_JOG_TWO_BIT];
    req_step = bus.pos_ctrl_word[`PCW_STEP_BIT];
    for (int t = 0; t < `TERM_COUNT; t++) begin
      if (term_s2_r[t] && bus.term_func[t*8 +: 8] == `FN_JOG_ONE)
        req_one = 1'b1;
      if (term_s2_r[t] && bus.term_func[t*8 +: 8] == `FN_JOG_TWO)
        req_two = 1'b1;
      if (term_s2_r[t] && bus.term_func[t*8 +: 8] == `FN_STEP_JOG)
        req_step = 1'b1;
    end
  end

  // ==========================================
  // jog task state machine
  jog_state_t st_r;
  jog_state_t st_nxt;
  logic [31:0] sel_speed;
  assign sel_speed = req_one ? jog_one_speed_setpoint
                             : jog_two_speed_setpoint;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      JOG_IDLE: begin
        if (req_one && req_two) st_nxt = JOG_FAULT;
        else if (req_one || req_two) st_nxt = JOG_RUN;
      end
      JOG_RUN: begin
        if (req_one && req_two) st_nxt = JOG_FAULT;
        else if (!req_one && !req_two) st_nxt = JOG_IDLE;
      end
      JOG_DONE:  if (!req_one && !req_two) st_nxt = JOG_IDLE;
      JOG_FAULT: if (!req_one && !req_two) st_nxt = JOG_IDLE;
      default:   st_nxt = JOG_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= JOG_IDLE;
      jog_active_r <= 1'b0;
      jog_dir_neg_r <= 1'b0;
      jog_speed_r <= 32'h0;
      jog_step_r <= 1'b0;
      jog_dist_r <= 32'h0;
      jog_fault_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      jog_active_r <= (st_nxt == JOG_RUN);
      jog_fault_r <= (st_nxt == JOG_FAULT);
      if (st_r == JOG_IDLE && st_nxt == JOG_RUN) begin
        // latch the task at request start; each restart latches it again
        jog_dir_neg_r <= sel_speed[31];
        jog_speed_r <= sel_speed[31] ? (32'h0 - sel_speed)
                                     : sel_speed;
        jog_step_r <= req_step;
        jog_dist_r <= req_one ? jog_one_step_distance
                              : jog_two_step_distance;
      end
    end
  end
endmodule

// file: design/block_table_if.sv
// ==========================================
// link between fieldbus or terminal side and the block table
interface block_table_if;
  import block_table_pkg::*;
  logic        wr_stb;     // program one slot
  logic [5:0]  wr_slot;
  logic [7:0]  wr_no;
  logic [31:0] wr_pos;
  logic [31:0] wr_vel;
  logic [7:0]  wr_acc;
  logic [7:0]  wr_dec;
  logic [3:0]  wr_cmd;
  logic [15:0] wr_par;
  logic [15:0] wr_mode;
  logic        start_stb;  // start a slot
  logic [5:0]  start_slot;
  logic [15:0] ctrl_word;
  logic [15:0] pos_ctrl_word;
  logic [3:0]  term_level;
  logic [31:0] term_func;  // 8-bit function number per terminal
  modport master (output wr_stb, wr_slot, wr_no, wr_pos, wr_vel, wr_acc,
    wr_dec, wr_cmd, wr_par, wr_mode, start_stb, start_slot, ctrl_word,
    pos_ctrl_word, term_level, term_func);
  modport drive (input wr_stb, wr_slot, wr_no, wr_pos, wr_vel, wr_acc,
    wr_dec, wr_cmd, wr_par, wr_mode, start_stb, start_slot, ctrl_word,
    pos_ctrl_word, term_level, term_func);
endinterface

// file: design/block_table_master.sv
`include "block_table_consts.svh"
// ==========================================
// controller end: registers user requests onto the link
module block_table_master (
  input  wire logic        clk,          // drive clock
  input  wire logic        sys_rst,      // sync reset
  input  wire logic        u_wr,         // program request
  input  wire logic [5:0]  u_slot,       // slot index
  input  wire logic [7:0]  u_no,         // block number, 0..63
  input  wire logic [31:0] u_pos,        // target
  input  wire logic [31:0] u_vel,        // velocity
  input  wire logic [7:0]  u_acc,        // accel override
  input  wire logic [7:0]  u_dec,        // decel override
  input  wire logic [3:0]  u_cmd,        // command
  input  wire logic [15:0] u_par,        // command parameter
  input  wire logic [15:0] u_mode,       // mode word
  input  wire logic        u_start,      // start request
  input  wire logic [5:0]  u_start_slot, // slot to start
  input  wire logic [15:0] u_ctrl,       // control word 1
  input  wire logic [15:0] u_pos_ctrl,   // positioning control word
  input  wire logic [3:0]  u_term,       // terminal levels
  input  wire logic [31:0] u_func,       // terminal functions
  block_table_if.master    bus           // link
);
  import block_table_pkg::*;
  // registered drive of all link signals
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.wr_stb <= 1'b0;
      bus.start_stb <= 1'b0;
      bus.ctrl_word <= 16'h0000;
      bus.pos_ctrl_word <= 16'h0000;
      bus.term_level <= 4'h0;
      bus.term_func <= 32'h00000000;
      bus.wr_slot <= 6'h00;
      bus.wr_no <= `BT_NO_RST;
      bus.wr_pos <= 32'h0;
      bus.wr_vel <= 32'h0;
      bus.wr_acc <= 8'h0;
      bus.wr_dec <= 8'h0;
      bus.wr_cmd <= 4'h0;
      bus.wr_par <= 16'h0;
      bus.wr_mode <= 16'h0;
      bus.start_slot <= 6'h00;
    end else begin
      bus.wr_stb <= u_wr;
      bus.start_stb <= u_start;
      bus.ctrl_word <= u_ctrl;
      bus.pos_ctrl_word <= u_pos_ctrl;
      bus.term_level <= u_term;
      bus.term_func <= u_func;
      bus.wr_slot <= u_slot;
      bus.wr_no <= u_no;
      bus.wr_pos <= u_pos;
      bus.wr_vel <= u_vel;
      bus.wr_acc <= u_acc;
      bus.wr_dec <= u_dec;
      bus.wr_cmd <= u_cmd;
      bus.wr_par <= u_par;
      bus.wr_mode <= u_mode;
      bus.start_slot <= u_start_slot;
    end
  end
endmodule

// file: design/block_table_pkg.sv
package block_table_pkg;
  // ==========================================
  // command codes
  typedef enum logic [3:0] {
    CMD_NONE        = 4'h0,
    CMD_POSITION    = 4'h1,
    CMD_RUN_PLUS    = 4'h2,
    CMD_RUN_MINUS   = 4'h3,
    CMD_WAIT        = 4'h4,
    CMD_JUMP        = 4'h5,
    CMD_SET_OUT     = 4'h6,
    CMD_CLR_OUT     = 4'h7,
    CMD_HARD_STOP   = 4'h8,
    CMD_COUPLE      = 4'h9,
    CMD_UNCOUPLE    = 4'ha
  } cmd_t;
  typedef enum logic [1:0] {
    CHG_END = 2'h0, CHG_STOP_GO = 2'h1, CHG_FLY = 2'h2, CHG_TRIG = 2'h3
  } chg_t;
  typedef enum logic [1:0] {
    POS_ABS = 2'h0, POS_REL = 2'h1, POS_ABS_PLUS = 2'h2, POS_ABS_MINUS = 2'h3
  } pos_t;
  // jog task states, one-hot
  typedef enum logic [3:0] {
    JOG_IDLE  = 4'b0001,
    JOG_RUN   = 4'b0010,
    JOG_DONE  = 4'b0100,
    JOG_FAULT = 4'b1000
  } jog_state_t;
endpackage

// file: verification/block_table_properties.sv
// ==========================================
// link and drive output checks
module block_table_properties (
  input wire logic        clk,          // drive clock
  input wire logic        sys_rst,      // sync reset
  input wire logic        start_stb,    // start strobe on link
  input wire logic [15:0] ctrl_word,    // control word 1
  input wire logic [3:0]  term_level,   // terminal levels
  input wire logic        blk_valid_r,  // block accepted
  input wire logic        blk_reject_r, // start refused
  input wire logic [31:0] blk_target_r, // target
  input wire logic [31:0] blk_vel_r,    // velocity
  input wire logic [15:0] blk_par_r,    // command operand
  input wire block_table_pkg::cmd_t blk_cmd_r, // command
  input wire logic        jog_active_r, // jog running
  input wire logic        jog_fault_r   // both jogs fault
);
  timeunit 1ns;
  timeprecision 1ps;
  import block_table_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_reject_clears; blk_reject_r |-> !blk_valid_r; endproperty
  a_reject_clears: assert property (p_reject_clears)
    else $error("refused start left valid set");
  property p_reject_cause; blk_reject_r |-> $past(start_stb); endproperty
  a_reject_cause: assert property (p_reject_cause)
    else $error("refusal without a start");
  property p_valid_cause; $rose(blk_valid_r) |-> $past(start_stb); endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("block valid without a start");
  property p_fields_hold;
    (!$past(start_stb) || blk_reject_r)
      |-> $stable({blk_target_r, blk_vel_r, blk_par_r, blk_cmd_r});
  endproperty
  a_fields_hold: assert property (p_fields_hold)
    else $error("block fields moved without accepted start");
  property p_both_fault; ctrl_word[9:8] == 2'h3 |=> jog_fault_r; endproperty
  a_both_fault: assert property (p_both_fault)
    else $error("both jog bits gave no fault");
  property p_fault_still; jog_fault_r |-> !jog_active_r; endproperty
  a_fault_still: assert property (p_fault_still)
    else $error("jog runs during fault");
  property p_release_stop;
    (ctrl_word[9:8] == 2'h0 && term_level == 4'h0) [*3] |=> !jog_active_r;
  endproperty
  a_release_stop: assert property (p_release_stop)
    else $error("jog still active after release");
  property p_jog_one_go;
    ctrl_word[9:8] == 2'h1 && $past(ctrl_word[9:8]) == 2'h0 &&
      ~|{term_level, $past(term_level), $past(term_level, 2)}
      |=> jog_active_r;
  endproperty
  a_jog_one_go: assert property (p_jog_one_go)
    else $error("jog one bit did not start jog");
endmodule

// file: verification/traverse_block_table_jog_select_bench.sv
// ==========================================
// bench for both link ends
module traverse_block_table_jog_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import block_table_pkg::*;
  typedef struct {bit jog; int due; logic [171:0] e; logic [171:0] m;} note_t;
  localparam logic [171:0] af_mask = {104'h0, 2'h3, 66'h0};
  logic clk = 0, sys_rst = 1, u_wr = 0, u_start = 0;
  logic [5:0] u_slot = 0, u_start_slot = 0;
  logic [7:0] u_no = 0, u_acc = 0, u_dec = 0;
  logic [3:0] u_cmd = 0, u_term = 0;
  logic [15:0] u_par = 0, u_mode = 0, u_ctrl = 0, u_pos_ctrl = 0;
  logic [31:0] u_pos = 0, u_vel = 0, u_func = 32'h103d3f3e;
  logic [31:0] max_accel_param, max_decel_param;
  logic [31:0] jog_one_speed_setpoint, jog_two_speed_setpoint;
  logic [31:0] jog_one_step_distance, jog_two_step_distance;
  logic blk_valid_r, blk_reject_r, blk_src_bus_r, blk_skip_r;
  logic jog_active_r, jog_dir_neg_r, jog_step_r, jog_fault_r;
  logic [31:0] blk_target_r, blk_vel_r, jog_speed_r, jog_dist_r;
  logic [39:0] blk_accel_r, blk_decel_r;
  logic [15:0] blk_par_r;
  cmd_t blk_cmd_r;
  chg_t blk_chg_r;
  pos_t blk_pos_r;
  logic [7:0] m_no [64];
  logic [169:0] m_f [64];
  logic [169:0] last_f = '0;
  int cyc = 0, n_errors = 0, checks_done = 0;
  note_t q[$];
  wire logic [171:0] bv = {blk_reject_r, blk_valid_r, blk_target_r,
    blk_vel_r, blk_accel_r, blk_decel_r, blk_cmd_r, blk_par_r, blk_chg_r,
    blk_pos_r, blk_src_bus_r, blk_skip_r};
  wire logic [67:0] jv = {jog_active_r, jog_fault_r, jog_dir_neg_r,
    jog_speed_r, jog_step_r, jog_dist_r};
  block_table_if link ();
  block_table_master u_block_table_master (.*, .bus(link));
  block_table_drive u_block_table_drive (.*, .bus(link));
  block_table_properties chk (.*, .start_stb(link.start_stb),
    .ctrl_word(link.ctrl_word), .term_level(link.term_level));
  // clock and cycle count
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // block result: every field of the last accepted slot
  task automatic cmp_blk(logic [171:0] e);
    checks_done++;
    if (bv !== e) begin
      n_errors++;
      $display("BAD block exp %h got %h", e, bv);
    end
  endtask
  // jog result: only the fields that the note selects
  task automatic cmp_jog(logic [67:0] e, logic [67:0] m);
    checks_done++;
    if ((jv & m) !== (e & m)) begin
      n_errors++;
      $display("BAD jog exp %h got %h", e & m, jv & m);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic note(bit jog, int lat, logic [171:0] e, logic [171:0] m);
    q.push_back('{jog, cyc + lat, e, m});
  endtask
  // compare each note as it falls due
  always @(posedge clk) begin
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      if (q[0].jog) cmp_jog(q[0].e[67:0], q[0].m[67:0]);
      else cmp_blk(q[0].e);
      void'(q.pop_front());
    end
  end
  task automatic wr(logic [5:0] s, logic [7:0] no, logic [3:0] c,
    logic [15:0] md);
    u_wr = 1; u_slot = s; u_no = no; u_cmd = c; u_mode = md;
    u_pos = $urandom; u_vel = $urandom; u_par = 16'($urandom);
    u_acc = 8'($urandom); u_dec = 8'($urandom);
    m_no[s] = no;
    m_f[s] = {u_pos, u_vel, 40'(u_acc) * 40'(max_accel_param),
      40'(u_dec) * 40'(max_decel_param), (c > 4'ha) ? 4'h0 : c, u_par,
      md[9:8], md[5:4], md[12], md[0]};
    tick;
    u_wr = 0;
  endtask
  task automatic st(logic [5:0] s);
    u_start = 1; u_start_slot = s;
    if (m_no[s] <= 8'h3f) last_f = m_f[s];
    note(0, 2, {m_no[s] > 8'h3f, m_no[s] <= 8'h3f, last_f}, '1);
    tick;
    u_start = 0;
  endtask
  task automatic jog(int k);
    logic two, trm, stp;
    logic [31:0] sp, d;
    two = k[0]; trm = k[1]; stp = (k == 1 || k == 2);
    jog_one_speed_setpoint = $urandom; jog_two_speed_setpoint = $urandom;
    jog_one_step_distance = $urandom; jog_two_step_distance = $urandom;
    sp = two ? jog_two_speed_setpoint : jog_one_speed_setpoint;
    d = two ? jog_two_step_distance : jog_one_step_distance;
    if (trm) begin
      u_term = {1'b0, stp, two, ~two};
    end else begin
      u_ctrl = {6'h0, two, ~two, 8'h0};
      u_pos_ctrl = {10'h0, stp, 5'h0};
    end
    note(1, trm ? 4 : 2, {104'h0, 2'h2, sp[31], sp[31] ? -sp : sp, stp, d},
      {104'h0, 36'hf_ffff_ffff, {32{stp}}});
    repeat (6) tick;
    u_term = 0; u_ctrl = 0; u_pos_ctrl = 0;
    note(1, trm ? 4 : 2, '0, af_mask);
    repeat (6) tick;
  endtask
  // main sequence
  initial begin
    logic [5:0] s;
    void'($urandom(32'ha666));
    max_accel_param = $urandom; max_decel_param = $urandom;
    jog_one_speed_setpoint = 0; jog_two_speed_setpoint = 0;
    jog_one_step_distance = 0; jog_two_step_distance = 0;
    foreach (m_no[i]) m_no[i] = 8'hff;
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 0;
    tick;
    for (int c = 0; c < 16; c++) begin
      wr(6'(c), 8'(c * 4 + 3), 4'(c), {3'h0, 1'(c), 2'h0, 2'(c), 2'h0,
        2'(c >> 2), 3'h0, 1'(c >> 1)});
      st(6'(c));
    end
    wr(6'd20, 8'h40, 4'h1, 16'h0);
    st(6'd20);
    tick;
    st(6'd63);
    repeat (8) begin
      s = 6'(21 + $urandom % 40);
      wr(s, 8'($urandom % 128), 4'($urandom), {3'h0, 1'($urandom), 2'h0,
        2'($urandom), 2'h0, 2'($urandom), 3'h0, 1'($urandom)});
      st(s);
    end
    repeat (4) tick;
    $display("test blocks done");
    for (int k = 0; k < 4; k++) jog(k);
    u_ctrl = 16'h0300;
    note(1, 2, {104'h0, 2'h1, 66'h0}, af_mask);
    repeat (4) tick;
    u_ctrl = 0;
    note(1, 2, '0, af_mask);
    repeat (6) tick;
    $display("test jog done");
    finish_test;
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule
